//--- tmc_check_monitor.sv
// Assertions on the thermal monitor ports
`timescale 1ns/1ps
module tmc_check_monitor #(
    parameter int SMP_WINDOW_CYC = tmc_pkg::SMP_WINDOW_CYC_DEF
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic tempAboveShutdown,
    input wire logic sysRunState,
    input wire logic sysStandbyState,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic tempSensorPowerEn,
    input wire logic thermalShutdown,
    input wire logic powerGoodPinEnable,
    input wire logic analogMuxBufferEnable,
    input wire logic [4:0] analogMuxChannelSelect
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    // ========================================================================
    // Helper logic
    // Powered cycles in a row outside Run, where only the sampling window is legal
    logic [15:0] onCnt_r;
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            onCnt_r <= 16'h0;
        else if (sysRunState || !tempSensorPowerEn)
            onCnt_r <= 16'h0;
        else
            onCnt_r <= onCnt_r + 16'h1;
    end

    // ========================================================================
    // Bus handshakes
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    chk_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
        else $error("late write response");
    chk_bresp_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
        else $error("write response kept");
    chk_read_answer: assert property (s_rd_taken |=> s_axi_rvalid && !s_axi_arready)
        else $error("late read data");
    chk_rdata_clear: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read data kept");

    // ========================================================================
    // Thermal and mux behaviour
    chk_sd_cause: assert property ($rose(thermalShutdown) |-> $past(tempAboveShutdown, 4) && $past(tempAboveShutdown, 8))
        else $error("shutdown without crossing");
    chk_standby_window: assert property (sysStandbyState && !sysRunState |-> onCnt_r <= 16'(SMP_WINDOW_CYC + 2))
        else $error("standby window too long");
    chk_pg_mux_excl: assert property (powerGoodPinEnable |-> !analogMuxBufferEnable && analogMuxChannelSelect == 5'h00)
        else $error("mux active in power-good");
    chk_buf_temp_code: assert property (analogMuxBufferEnable |-> analogMuxChannelSelect == tmc_pkg::MUX_SEL_TEMP && !powerGoodPinEnable)
        else $error("buffer on wrong code");
    chk_off_pg_mode: assert property (!(sysRunState || sysStandbyState) |=> powerGoodPinEnable && !analogMuxBufferEnable)
        else $error("mux active when off");
endmodule

bind tmc_thermal_monitor tmc_check_monitor #(.SMP_WINDOW_CYC(SMP_WINDOW_CYC)) i_chk (.*);

//--- tmc_dummy_note_unused.sv
// Unused
`timescale 1ns/1ps

//--- tmc_pkg.sv
// Shared constants and types
package tmc_pkg;

    // ========================================================================
    // Clock and timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int DB_TIME_NS = 10000;
    localparam int DB_CYC = (DB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SMP_WINDOW_US = 450;
    localparam int SMP_INTERVAL_US = 3000;
    localparam int SMP_WINDOW_CYC_DEF = SMP_WINDOW_US * 1000 / CLK_PERIOD_NS;
    localparam int SMP_INTERVAL_CYC_DEF = SMP_INTERVAL_US * 1000 / CLK_PERIOD_NS;
    localparam int DB_W = 10;
    localparam int SMP_W = 19;
    localparam int NUM_THR = 6;

    // ========================================================================
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] MASK_OFS = 8'h08;
    localparam logic [7:0] SENSE_OFS = 8'h0c;

    // ========================================================================
    // Field positions
    localparam int CTRL_MON_EN_BIT = 0;
    localparam int CTRL_AON_BIT = 1;
    localparam int CTRL_MUX_EN_BIT = 2;
    localparam int CTRL_SEL_LSB = 8;
    localparam int SENSE_SD_BIT = 8;
    localparam int SENSE_PWR_BIT = 9;

    // ========================================================================
    // Reset values and codes
    localparam logic MON_EN_RST = 1'b1;
    localparam logic AON_RST = 1'b1;
    localparam logic MUX_EN_RST = 1'b0;
    localparam logic [4:0] MUX_SEL_RST = 5'h00;
    localparam logic [5:0] MASK_RST = 6'h00;
    localparam logic [4:0] MUX_SEL_HIZ = 5'h00;
    localparam logic [4:0] MUX_SEL_TEMP = 5'h07;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ========================================================================
    // Sensor sequencing states
    typedef enum logic [3:0] {
        SMP_OFF = 4'h1,
        SMP_CONT = 4'h2,
        SMP_WIN = 4'h4,
        SMP_IDLE = 4'h8
    } tmc_smp_e;

    // ========================================================================
    // Whole state of the block
    typedef struct packed {
        logic [5:0] thrMeta;
        logic [5:0] thrSync;
        logic [5:0] relMeta;
        logic [5:0] relSync;
        logic sdMeta;
        logic sdSync;
        logic sdRelMeta;
        logic sdRelSync;
        logic [6:0][DB_W-1:0] dbCnt;
        logic [5:0] sense;
        logic [5:0] irq;
        logic [5:0] mask;
        logic shutdown;
        logic monEn;
        logic aon;
        logic muxEn;
        logic [4:0] muxSel;
        tmc_smp_e smpState;
        logic [SMP_W-1:0] smpCnt;
        logic sensorPwr;
        logic irqN;
        logic pgoodEn;
        logic amuxBuf;
        logic [4:0] amuxSelOut;
        logic awHeld;
        logic [7:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic awRdy;
        logic wRdy;
        logic bValid;
        logic [1:0] bResp;
        logic arRdy;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
    } tmc_state_s;

endpackage

//--- tmc_tb.sv
// Testbench for the thermal monitor block
`timescale 1ns/1ps
module tb;
    // Short sampling counts
    localparam int WIN = 40;
    localparam int PER = 200;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [5:0] tempAboveThr = 6'h00;
    logic [5:0] tempAboveRelease = 6'h00;
    logic tempAboveShutdown = 1'b0;
    logic tempAboveRestart = 1'b0;
    logic sysRunState = 1'b1;
    logic sysStandbyState = 1'b0;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic tempSensorPowerEn, thermalShutdown, interruptOutN;
    logic powerGoodPinEnable, analogMuxBufferEnable;
    logic [4:0] analogMuxChannelSelect;
    int miscompares = 0;
    int samples_checked = 0;

    always #5 sys_clk = ~sys_clk;

    tmc_thermal_monitor #(.SMP_WINDOW_CYC(WIN), .SMP_INTERVAL_CYC(PER)) i_dut (.*);

    // ========================================================================
    // Shared helpers
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // Address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit done;
        done = 1'b0;
        r = 2'h3;
        @(posedge sys_clk);
        s_axi_awaddr <= {24'h0, a};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 50 && !done; n++)
        begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
            begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) check("wr_done", 32'h0, 32'h1);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit done;
        done = 1'b0;
        d = 32'h0;
        r = 2'h3;
        @(posedge sys_clk);
        s_axi_araddr <= {24'h0, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 50 && !done; n++)
        begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
            begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) check("rd_done", 32'h0, 32'h1);
    endtask

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        check(nm, d & m, e);
    endtask

    // One powered window and the rise-to-rise period
    task automatic meas(output int hi, output int per);
        int n;
        n = 0;
        while (tempSensorPowerEn !== 1'b0 && n < 1000) begin @(posedge sys_clk); n++; end
        while (tempSensorPowerEn !== 1'b1 && n < 2000) begin @(posedge sys_clk); n++; end
        hi = 0;
        while (tempSensorPowerEn === 1'b1 && hi < 1000) begin @(posedge sys_clk); hi++; end
        per = hi;
        while (tempSensorPowerEn !== 1'b1 && per < 1000) begin @(posedge sys_clk); per++; end
    endtask

    // ========================================================================
    // Scenarios
    task automatic t_reset();
        rdc("ctrl_rst", tmc_pkg::CTRL_OFS, 32'h00001f07, 32'h00000003);
        rdc("mask_rst", tmc_pkg::MASK_OFS, 32'h3f, 32'h0);
        check("pg_rst", 32'(powerGoodPinEnable), 32'h1);
    endtask

    // Unmapped place refused, nothing changed
    task automatic t_bad();
        logic [31:0] d;
        logic [1:0] r;
        wr(8'h10, 32'hffffffff, r);
        check("wr_bad", 32'(r), 32'(tmc_pkg::RESP_SLVERR));
        rd(8'h10, d, r);
        check("rd_bad", {d[29:0], r}, 32'(tmc_pkg::RESP_SLVERR));
        rdc("ctrl_kept", tmc_pkg::CTRL_OFS, 32'hffffffff, 32'h3);
    endtask

    // Each threshold: debounce, set, hysteresis, latch, mask, clear
    task automatic t_thr();
        logic [1:0] r;
        logic [31:0] b;
        for (int i = 0; i < 6; i++)
        begin
            b = 32'h1 << i;
            tempAboveThr[i] <= 1'b1;
            tempAboveRelease[i] <= 1'b1;
            cyc(985);
            rdc("sense_early", tmc_pkg::SENSE_OFS, b, 32'h0);
            cyc(30);
            rdc("sense_set", tmc_pkg::SENSE_OFS, 32'h3f, b);
            rdc("irq_set", tmc_pkg::STATUS_OFS, 32'h3f, b);
            check("int_low", 32'(interruptOutN), 32'h0);
            tempAboveThr[i] <= 1'b0;
            cyc(1100);
            rdc("sense_hys", tmc_pkg::SENSE_OFS, b, b);
            tempAboveRelease[i] <= 1'b0;
            cyc(1100);
            rdc("sense_clr", tmc_pkg::SENSE_OFS, b, 32'h0);
            rdc("irq_hold", tmc_pkg::STATUS_OFS, b, b);
            wr(tmc_pkg::MASK_OFS, b, r);
            cyc(2);
            check("int_masked", 32'(interruptOutN), 32'h1);
            wr(tmc_pkg::MASK_OFS, 32'h0, r);
            cyc(2);
            check("int_unmask", 32'(interruptOutN), 32'h0);
            wr(tmc_pkg::STATUS_OFS, b, r);
            rdc("irq_w1c", tmc_pkg::STATUS_OFS, 32'h3f, 32'h0);
            cyc(2);
            check("int_clr", 32'(interruptOutN), 32'h1);
        end
    endtask

    task automatic t_sd();
        tempAboveRestart <= 1'b1;
        tempAboveShutdown <= 1'b1;
        cyc(1020);
        check("sd_set", 32'(thermalShutdown), 32'h1);
        tempAboveShutdown <= 1'b0;
        cyc(1100);
        check("sd_hold", 32'(thermalShutdown), 32'h1);
        tempAboveRestart <= 1'b0;
        cyc(1100);
        check("sd_rel", 32'(thermalShutdown), 32'h0);
    endtask

    // Die temperature code last
    task automatic t_mux();
        logic [4:0] codes [4] = '{5'h00, 5'h05, 5'h1f, 5'h07};
        logic [1:0] r;
        foreach (codes[k])
        begin
            wr(tmc_pkg::CTRL_OFS, {19'h0, codes[k], 8'h07}, r);
            cyc(2);
            check("pg_off", 32'(powerGoodPinEnable), 32'h0);
            check("buf", 32'(analogMuxBufferEnable), 32'(codes[k] == 5'h07));
            check("sel", 32'(analogMuxChannelSelect), 32'(codes[k]));
        end
        sysRunState <= 1'b0;
        cyc(3);
        check("off_pg", {analogMuxChannelSelect, analogMuxBufferEnable, powerGoodPinEnable}, 32'h1);
        sysRunState <= 1'b1;
        wr(tmc_pkg::CTRL_OFS, 32'h3, r);
        cyc(2);
        check("dis_pg", {analogMuxChannelSelect, analogMuxBufferEnable, powerGoodPinEnable}, 32'h1);
    endtask

    task automatic t_smp();
        int hi, per, n;
        logic [1:0] r;
        wr(tmc_pkg::CTRL_OFS, 32'h1, r);
        meas(hi, per);
        check("win", 32'(hi), 32'(WIN));
        check("period", 32'(per), 32'(PER));
        sysRunState <= 1'b0;
        sysStandbyState <= 1'b1;
        wr(tmc_pkg::CTRL_OFS, 32'h3, r);
        meas(hi, per);
        check("stby_win", 32'(hi), 32'(WIN));
        wr(tmc_pkg::CTRL_OFS, 32'h2, r);
        cyc(2);
        n = 0;
        repeat (400) begin @(posedge sys_clk); if (tempSensorPowerEn !== 1'b0) n++; end
        check("mon_off", 32'(n), 32'h0);
        sysRunState <= 1'b1;
        sysStandbyState <= 1'b0;
        wr(tmc_pkg::CTRL_OFS, 32'h3, r);
        cyc(3);
        n = 0;
        repeat (300) begin @(posedge sys_clk); if (tempSensorPowerEn !== 1'b1) n++; end
        check("aon", 32'(n), 32'h0);
    endtask

    // ========================================================================
    // Run control
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        cyc(12);
        rst_b <= 1'b1;
        cyc(1);
        t_reset();
        t_bad();
        t_thr();
        t_sd();
        t_mux();
        t_smp();
        final_report();
    end

    // Watchdog well beyond the expected 24k cycles
    initial
    begin
        #600000;
        miscompares++;
        final_report();
    end
endmodule

//--- tmc_thermal_monitor.sv
// Thermal monitor control: debounce, flags, shutdown, sensing, mux
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps

// Operation
// - Six warning thresholds, each with irq flag, sense flag and mask bit.
// - A threshold crossing sets that threshold's interrupt flag.
// - Sense flag releases only below the 5 degree lower release comparator.
// - Shutdown sets on crossing, holds until the restart comparator drops.
// - Every comparison is debounced 10 us both rising and falling.
// - Monitor enable low disables monitoring; high lets it operate.
// - Run state with always-on set keeps the sensor powered continuously.
// - Always-on clear samples: 450 us powered every 3.0 ms.
// - Standby uses sampling only while monitor enable is set.
// - Mux enable low: mux off, shared pin is power-good output.
// - Mux enable high: power-good off, select field picks the channel.
// - Select 00000 is high impedance, 00111 is die temperature, others reserved.
// - Mux is enabled and usable only during the system On states.
// - Active-low interrupt pin asserts for any set, unmasked interrupt flag.
module tmc_thermal_monitor #(
    parameter int SMP_WINDOW_CYC = tmc_pkg::SMP_WINDOW_CYC_DEF,
    parameter int SMP_INTERVAL_CYC = tmc_pkg::SMP_INTERVAL_CYC_DEF
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [5:0] tempAboveThr,
    input wire logic [5:0] tempAboveRelease,
    input wire logic tempAboveShutdown,
    input wire logic tempAboveRestart,
    input wire logic sysRunState,
    input wire logic sysStandbyState,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic tempSensorPowerEn,
    output logic thermalShutdown,
    output logic interruptOutN,
    output logic powerGoodPinEnable,
    output logic analogMuxBufferEnable,
    output logic [4:0] analogMuxChannelSelect
);

    // ========================================================================
    // Helpers

    // Expand byte strobes into a bit mask
    function automatic logic [31:0] strbMask(input logic [3:0] strb);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++)
        begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction

    // Debounce step: count while levels differ, flip at the limit
    function automatic logic [tmc_pkg::DB_W:0] dbStep(
        input logic want,
        input logic cur,
        input logic run,
        input logic [tmc_pkg::DB_W-1:0] cnt
    );
        logic [tmc_pkg::DB_W:0] r;
        r = {1'b0, cnt};
        if (run && want == cur)
        begin
            r = '0;
        end
        else if (run && cnt == tmc_pkg::DB_W'(tmc_pkg::DB_CYC - 1))
        begin
            r = {1'b1, {tmc_pkg::DB_W{1'b0}}};
        end
        else if (run)
        begin
            r = {1'b0, cnt + tmc_pkg::DB_W'(1)};
        end
        return r;
    endfunction

    // ========================================================================
    // State

    tmc_pkg::tmc_state_s st_r;
    tmc_pkg::tmc_state_s st_nxt;
    // Next state of the whole block
    always_comb
    begin
        logic [tmc_pkg::DB_W:0] step;
        logic want, onState, aonRun, monActive, doWrite;
        logic [31:0] bm, wr, ctrl;
        logic [5:0] irqSet, irqClr;
        step = '0;
        want = 1'b0;
        onState = 1'b0;
        aonRun = 1'b0;
        monActive = 1'b0;
        bm = '0;
        wr = '0;
        irqSet = '0;
        irqClr = '0;
        doWrite = 1'b0;
        ctrl = {19'h0, st_r.muxSel, 5'h0, st_r.muxEn, st_r.aon, st_r.monEn};
        st_nxt = st_r;
        // Two-stage synchronisers for the analog comparators
        st_nxt.thrMeta = tempAboveThr;
        st_nxt.thrSync = st_r.thrMeta;
        st_nxt.relMeta = tempAboveRelease;
        st_nxt.relSync = st_r.relMeta;
        st_nxt.sdMeta = tempAboveShutdown;
        st_nxt.sdSync = st_r.sdMeta;
        st_nxt.sdRelMeta = tempAboveRestart;
        st_nxt.sdRelSync = st_r.sdRelMeta;
        onState = sysRunState | sysStandbyState;
        aonRun = sysRunState & st_r.aon;
        monActive = st_r.monEn & onState;
        // Sensor power sequencing
        case (st_r.smpState)
            tmc_pkg::SMP_OFF:
            begin
                st_nxt.smpCnt = '0;
                if (monActive)
                begin
                    st_nxt.smpState = aonRun ? tmc_pkg::SMP_CONT : tmc_pkg::SMP_WIN;
                end
            end
            tmc_pkg::SMP_CONT:
            begin
                st_nxt.smpCnt = '0;
                if (!monActive)
                begin
                    st_nxt.smpState = tmc_pkg::SMP_OFF;
                end
                else if (!aonRun)
                begin
                    st_nxt.smpState = tmc_pkg::SMP_WIN;
                end
            end
            tmc_pkg::SMP_WIN:
            begin
                st_nxt.smpCnt = st_r.smpCnt + tmc_pkg::SMP_W'(1);
                if (!monActive)
                begin
                    st_nxt.smpState = tmc_pkg::SMP_OFF;
                end
                else if (aonRun)
                begin
                    st_nxt.smpState = tmc_pkg::SMP_CONT;
                end
                else if (st_r.smpCnt == tmc_pkg::SMP_W'(SMP_WINDOW_CYC - 1))
                begin
                    st_nxt.smpState = tmc_pkg::SMP_IDLE;
                end
            end
            tmc_pkg::SMP_IDLE:
            begin
                st_nxt.smpCnt = st_r.smpCnt + tmc_pkg::SMP_W'(1);
                if (!monActive)
                begin
                    st_nxt.smpState = tmc_pkg::SMP_OFF;
                end
                else if (aonRun)
                begin
                    st_nxt.smpState = tmc_pkg::SMP_CONT;
                end
                else if (st_r.smpCnt == tmc_pkg::SMP_W'(SMP_INTERVAL_CYC - 1))
                begin
                    st_nxt.smpState = tmc_pkg::SMP_WIN;
                    st_nxt.smpCnt = '0;
                end
            end
            default:
            begin
                st_nxt.smpState = tmc_pkg::SMP_OFF;
                st_nxt.smpCnt = '0;
            end
        endcase
        st_nxt.sensorPwr = (st_nxt.smpState == tmc_pkg::SMP_CONT) ||
                           (st_nxt.smpState == tmc_pkg::SMP_WIN);
        // Six warnings debounced; counters freeze while the sensor is off
        for (int i = 0; i < tmc_pkg::NUM_THR; i++)
        begin
            want = st_r.sense[i] ? st_r.relSync[i] : st_r.thrSync[i];
            step = dbStep(want, st_r.sense[i], st_r.sensorPwr, st_r.dbCnt[i]);
            st_nxt.dbCnt[i] = step[tmc_pkg::DB_W-1:0];
            if (step[tmc_pkg::DB_W])
            begin
                st_nxt.sense[i] = ~st_r.sense[i];
            end
        end
        // Shutdown channel holds until the restart comparator falls
        want = st_r.shutdown ? st_r.sdRelSync : st_r.sdSync;
        step = dbStep(want, st_r.shutdown, st_r.sensorPwr, st_r.dbCnt[6]);
        st_nxt.dbCnt[6] = step[tmc_pkg::DB_W-1:0];
        if (step[tmc_pkg::DB_W])
        begin
            st_nxt.shutdown = ~st_r.shutdown;
        end
        // Disabled monitor forgets all live state
        if (!st_r.monEn)
        begin
            st_nxt.sense = '0;
            st_nxt.shutdown = 1'b0;
            st_nxt.dbCnt = '0;
        end
        irqSet = st_nxt.sense & ~st_r.sense;
        // AXI write: address and data in either order
        if (s_axi_awvalid && st_r.awRdy)
        begin
            st_nxt.awHeld = 1'b1;
            st_nxt.awAddr = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && st_r.wRdy)
        begin
            st_nxt.wHeld = 1'b1;
            st_nxt.wData = s_axi_wdata;
            st_nxt.wStrb = s_axi_wstrb;
        end
        if (st_r.bValid && s_axi_bready)
        begin
            st_nxt.bValid = 1'b0;
        end
        doWrite = st_r.awHeld && st_r.wHeld && !st_r.bValid;
        bm = strbMask(st_r.wStrb);
        if (doWrite)
        begin
            st_nxt.awHeld = 1'b0;
            st_nxt.wHeld = 1'b0;
            st_nxt.bValid = 1'b1;
            st_nxt.bResp = tmc_pkg::RESP_OKAY;
            case (st_r.awAddr)
                tmc_pkg::CTRL_OFS:
                begin
                    wr = ctrl;
                    wr = (wr & ~bm) | (st_r.wData & bm);
                    st_nxt.monEn = wr[tmc_pkg::CTRL_MON_EN_BIT];
                    st_nxt.aon = wr[tmc_pkg::CTRL_AON_BIT];
                    st_nxt.muxEn = wr[tmc_pkg::CTRL_MUX_EN_BIT];
                    st_nxt.muxSel = wr[tmc_pkg::CTRL_SEL_LSB +: 5];
                end
                tmc_pkg::STATUS_OFS:
                begin
                    irqClr = st_r.wData[5:0] & bm[5:0];
                end
                tmc_pkg::MASK_OFS:
                begin
                    st_nxt.mask = (st_r.mask & ~bm[5:0]) | (st_r.wData[5:0] & bm[5:0]);
                end
                tmc_pkg::SENSE_OFS:
                begin
                    st_nxt.bResp = tmc_pkg::RESP_OKAY; // Read-only, write ignored
                end
                default:
                begin
                    st_nxt.bResp = tmc_pkg::RESP_SLVERR;
                end
            endcase
        end
        // A new crossing beats a clear in the same cycle
        st_nxt.irq = (st_r.irq & ~irqClr) | irqSet;
        st_nxt.awRdy = !st_nxt.awHeld;
        st_nxt.wRdy = !st_nxt.wHeld;
        // AXI read channel, one read under way at a time
        if (st_r.rValid && s_axi_rready)
        begin
            st_nxt.rValid = 1'b0;
        end
        if (s_axi_arvalid && st_r.arRdy)
        begin
            st_nxt.rValid = 1'b1;
            st_nxt.rResp = tmc_pkg::RESP_OKAY;
            st_nxt.rData = '0;
            case (s_axi_araddr[7:0])
                tmc_pkg::CTRL_OFS:
                begin
                    st_nxt.rData = ctrl;
                end
                tmc_pkg::STATUS_OFS:
                begin
                    st_nxt.rData = {26'h0, st_r.irq};
                end
                tmc_pkg::MASK_OFS:
                begin
                    st_nxt.rData = {26'h0, st_r.mask};
                end
                tmc_pkg::SENSE_OFS:
                begin
                    st_nxt.rData = {22'h0, st_r.sensorPwr, st_r.shutdown, 2'h0, st_r.sense};
                end
                default:
                begin
                    st_nxt.rResp = tmc_pkg::RESP_SLVERR;
                end
            endcase
        end
        st_nxt.arRdy = !st_nxt.rValid;
        // Interrupt pin, low for any unmasked flag
        st_nxt.irqN = ~|(st_nxt.irq & ~st_nxt.mask);
        // Shared pin: mux only inside On states, temperature only on its code
        if (st_nxt.muxEn && onState)
        begin
            st_nxt.pgoodEn = 1'b0;
            st_nxt.amuxSelOut = st_nxt.muxSel;
            st_nxt.amuxBuf = (st_nxt.muxSel == tmc_pkg::MUX_SEL_TEMP);
        end
        else
        begin
            st_nxt.pgoodEn = 1'b1;
            st_nxt.amuxSelOut = tmc_pkg::MUX_SEL_HIZ;
            st_nxt.amuxBuf = 1'b0;
        end
    end

    // ========================================================================
    // Register the whole state; reset loads constants only
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_r <= '0;
            st_r.monEn <= tmc_pkg::MON_EN_RST;
            st_r.aon <= tmc_pkg::AON_RST;
            st_r.muxEn <= tmc_pkg::MUX_EN_RST;
            st_r.muxSel <= tmc_pkg::MUX_SEL_RST;
            st_r.mask <= tmc_pkg::MASK_RST;
            st_r.smpState <= tmc_pkg::SMP_OFF;
            st_r.irqN <= 1'b1;
            st_r.pgoodEn <= 1'b1;
            st_r.awRdy <= 1'b1;
            st_r.wRdy <= 1'b1;
            st_r.arRdy <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ========================================================================
    // Outputs, each straight from a state flip-flop
    assign s_axi_awready = st_r.awRdy;
    assign s_axi_wready = st_r.wRdy;
    assign s_axi_bvalid = st_r.bValid;
    assign s_axi_bresp = st_r.bResp;
    assign s_axi_arready = st_r.arRdy;
    assign s_axi_rvalid = st_r.rValid;
    assign s_axi_rdata = st_r.rData;
    assign s_axi_rresp = st_r.rResp;
    assign tempSensorPowerEn = st_r.sensorPwr;
    assign thermalShutdown = st_r.shutdown;
    assign interruptOutN = st_r.irqN;
    assign powerGoodPinEnable = st_r.pgoodEn;
    assign analogMuxBufferEnable = st_r.amuxBuf;
    assign analogMuxChannelSelect = st_r.amuxSelOut;
endmodule
